// ===== pkg/ste_pkg.sv
// package for the set point threshold evaluator: constants, types, behaviour notes
// Notes on behaviour
// - thirty-two set points, each with stored parameters and its own trip state.
// - each new trip sends an event naming the tripped set point index.
// - seven relay drives and one logic output follow set points one to eight.
// - two LEDs show the trip state of set points one and two.
// - any set point may blink, blank the weight or show a message.
// - a trip may send its message to the serial port, per set point.
// - two thresholds per set point, joined by AND or OR.
// - each threshold has its own greater or less comparison operator.
// - each threshold selects gross, net, total weight or weighment count.
// - each set point selects its source entry of the channel list.
// - a latching set point stays asserted after its condition goes false.
// - trip delay of up to ten thousand milliseconds before asserting.
// - per set point enable suppresses operation but keeps its parameters.
// - one global enable turns all thirty-two set points off or on.
// - greater-than with preact: assert and release at threshold minus preact.
// - greater-than with postact: assert and release at threshold plus postact.
// - greater-than with deadzone: assert at threshold, release at threshold minus deadzone.
// - preact or postact with deadzone: release at shifted threshold minus deadzone.
// - less-than comparisons apply all three offsets in the reverse direction.
// - offsets apply identically to both thresholds of a set point.
// - condition false before delay elapses: no trip, delay restarts later.
// - a latched output clears on reset, on a clear-latch command, or when its enable or the global enable drops.
// - message sent once per false-to-true transition of the set point.
// - combine mode none ignores the second threshold entirely.
package ste_pkg;

  // counts and widths
  localparam int NUM_SP = 32;
  localparam int SP_IDX_W = 5;
  localparam int VAL_W = 32;
  localparam int OFS_W = 24;
  localparam int DLY_W = 14;
  localparam int TS_W = 16;
  localparam int NUM_RELAY = 7;
  localparam int NUM_LED = 2;

  // timing: one millisecond tick derived from the system clock
  localparam int CLK_FREQ_HZ = 125_000_000;
  localparam int TICK_MS = 1;
  localparam int TICK_CYCLES = CLK_FREQ_HZ / 1000 * TICK_MS;
  localparam int MAX_DELAY_MS = 10000;

  // reset values
  localparam logic [NUM_SP-1:0] SP_VEC_RST = 32'h0000_0000;
  localparam logic [TS_W-1:0] TS_RST = 16'h0000;

  // comparison operators
  typedef enum logic [2:0] {
    OP_NONE = 3'b000,
    OP_GT   = 3'b001,
    OP_GE   = 3'b010,
    OP_LT   = 3'b011,
    OP_LE   = 3'b100
  } ste_op_t;

  // compared quantities
  typedef enum logic [1:0] {
    Q_GROSS = 2'b00,
    Q_NET   = 2'b01,
    Q_TOTAL = 2'b10,
    Q_COUNT = 2'b11
  } ste_qsel_t;

  // joining of the two comparisons
  typedef enum logic [1:0] {
    CMB_NONE = 2'b00,
    CMB_AND  = 2'b01,
    CMB_OR   = 2'b10
  } ste_cmb_t;

  // local display behaviour
  typedef enum logic [1:0] {
    SCR_NORMAL = 2'b00,
    SCR_MSG    = 2'b01,
    SCR_BLANK  = 2'b10,
    SCR_BLINK  = 2'b11
  } ste_scr_t;

  // one channel list sample
  typedef struct packed {
    logic signed [VAL_W-1:0] gross;
    logic signed [VAL_W-1:0] net;
    logic signed [VAL_W-1:0] total;
    logic signed [VAL_W-1:0] weighment_count;
  } ste_quant_t;

  // value modifiers, unsigned amounts
  typedef struct packed {
    logic [OFS_W-1:0] preact;
    logic [OFS_W-1:0] postact;
    logic [OFS_W-1:0] deadzone;
  } ste_ofs_t;

  // full parameter set of one set point
  typedef struct packed {
    logic enable;
    logic latch;
    logic [DLY_W-1:0] delay_ms;
    ste_cmb_t threshold_combine_mode;
    ste_op_t op1;
    ste_op_t op2;
    ste_qsel_t first_quantity_select;
    ste_qsel_t second_quantity_select;
    logic [SP_IDX_W-1:0] src;
    logic signed [VAL_W-1:0] value1;
    logic signed [VAL_W-1:0] value2;
    ste_ofs_t ofs;
    ste_scr_t screen;
    logic msg_to_serial;
    logic msg_to_display;
  } ste_cfg_t;

  // trip event towards indicators and message senders
  typedef struct packed {
    logic [SP_IDX_W-1:0] idx;
    logic to_serial;
    logic to_display;
  } ste_evt_t;

endpackage : ste_pkg

// ===== rtl/ste_tick.sv
// millisecond enable pulse divider
`timescale 1ns/1ns
module ste_tick #(
  parameter int P_CYCLES = 125000
) (
  // clock and reset
  input wire logic i_clk_sys,
  input wire logic i_rst_n,
  // tick out
  output logic o_tick
);

  localparam int CW = $clog2(P_CYCLES + 1);
  localparam logic [CW-1:0] LAST = CW'(P_CYCLES - 1);

  logic [CW-1:0] cnt_r;
  logic wrap_w;

  generate
    if (P_CYCLES < 1) begin : g_bad
      $error("ste_tick: P_CYCLES must be at least one");
    end
  endgenerate

  // wrap when the period is complete
  assign wrap_w = (cnt_r == LAST);

  // counter and one-cycle pulse
  always_ff @(posedge i_clk_sys) begin
    if (!i_rst_n) begin
      cnt_r <= '0;
      o_tick <= 1'b0;
    end else begin
      cnt_r <= wrap_w ? '0 : cnt_r + CW'(1);
      o_tick <= wrap_w;
    end
  end

endmodule : ste_tick

// ===== rtl/ste_cmp.sv
// one threshold comparison with preact, postact and deadzone
`timescale 1ns/1ns
module ste_cmp
  import ste_pkg::*;
(
  // sample and selection
  input ste_pkg::ste_quant_t i_quant,
  input ste_pkg::ste_qsel_t i_qsel,
  // threshold settings
  input ste_pkg::ste_op_t i_op,
  input wire logic signed [ste_pkg::VAL_W-1:0] i_value,
  input ste_pkg::ste_ofs_t i_ofs,
  // previous state of this comparison
  input wire logic i_was_on,
  // result
  output logic o_hit
);

  localparam int AW = VAL_W + 2;

  logic signed [VAL_W-1:0] q_sel;
  logic signed [AW-1:0] q_w, v_w, pre_w, post_w, dz_w;
  logic signed [AW-1:0] on_pt_w, off_pt_w, thr_w;
  logic upward_w;

  // quantity picked for this threshold
  assign q_sel = (i_qsel == Q_GROSS) ? i_quant.gross :
                 (i_qsel == Q_NET) ? i_quant.net :
                 (i_qsel == Q_TOTAL) ? i_quant.total : i_quant.weighment_count;

  // widen by two bits so three-term sums cannot overflow
  assign q_w = AW'(q_sel);
  assign v_w = AW'(i_value);
  assign pre_w = AW'({1'b0, i_ofs.preact});
  assign post_w = AW'({1'b0, i_ofs.postact});
  assign dz_w = AW'({1'b0, i_ofs.deadzone});

  // shifted trip point, reversed for less-than
  assign upward_w = (i_op == OP_GT) || (i_op == OP_GE);
  assign on_pt_w = upward_w ? (v_w - pre_w + post_w) : (v_w + pre_w - post_w);
  // release point moved by the deadzone
  assign off_pt_w = upward_w ? (on_pt_w - dz_w) : (on_pt_w + dz_w);
  assign thr_w = i_was_on ? off_pt_w : on_pt_w;

  // relation per operator, none never satisfied
  always_comb begin
    case (i_op)
      OP_GT: o_hit = (q_w > thr_w);
      OP_GE: o_hit = (q_w >= thr_w);
      OP_LT: o_hit = (q_w < thr_w);
      OP_LE: o_hit = (q_w <= thr_w);
      default: o_hit = 1'b0;
    endcase
  end

endmodule : ste_cmp

// ===== rtl/ste_top.sv
// set point threshold evaluator: parameter store, scanner, timers, outputs
`timescale 1ns/1ns
module ste_top
  import ste_pkg::*;
#(
  parameter int P_TICK_CYCLES = ste_pkg::TICK_CYCLES
) (
  // clock and reset
  input wire logic i_clk_sys,
  input wire logic i_rst_n,
  // parameter store write
  input wire logic i_cfg_wr,
  input wire logic [ste_pkg::SP_IDX_W-1:0] i_cfg_idx,
  input ste_pkg::ste_cfg_t i_cfg,
  // channel list samples
  input wire logic i_chan_valid,
  input wire logic [ste_pkg::SP_IDX_W-1:0] i_chan_idx,
  input ste_pkg::ste_quant_t i_chan_sample,
  // control levels and commands
  input wire logic i_global_setpoint_enable,
  input wire logic i_clr_latch,
  // discrete outputs
  output logic [ste_pkg::NUM_RELAY-1:0] o_relay,
  output logic o_logic_out,
  output logic [ste_pkg::NUM_LED-1:0] o_led,
  output logic [ste_pkg::NUM_SP-1:0] o_trip,
  // display control
  output logic o_blank,
  output logic o_blink,
  // trip event
  output logic o_evt_valid,
  output ste_pkg::ste_evt_t o_evt
);

  // elaboration checks: scanner wrap, fixed output map and delay timer depend on these
  generate
    if (P_TICK_CYCLES < 1) begin : g_bad_tick
      $error("ste_top: P_TICK_CYCLES must be at least one");
    end
    // the round-robin index must wrap exactly after the last point
    if (NUM_SP != (1 << SP_IDX_W)) begin : g_bad_idx
      $error("ste_top: NUM_SP must be two to the power SP_IDX_W");
    end
    // relays, logic output and leds follow the lowest points
    if (NUM_RELAY + 1 > NUM_SP) begin : g_bad_relay
      $error("ste_top: fixed relay map needs more set points");
    end
    if (NUM_LED > NUM_SP) begin : g_bad_led
      $error("ste_top: fixed led map needs more set points");
    end
    // the delay field must hold the ten-second ceiling
    if (MAX_DELAY_MS >= (1 << DLY_W)) begin : g_bad_dly
      $error("ste_top: DLY_W too narrow for MAX_DELAY_MS");
    end
    // the stamp must outrun the longest delay or the elapsed time wraps
    if (MAX_DELAY_MS >= (1 << (TS_W - 1))) begin : g_bad_ts
      $error("ste_top: TS_W too narrow for MAX_DELAY_MS");
    end
  endgenerate

  // parameter and sample memories, one word per set point or channel
  ste_cfg_t cfg_mem [NUM_SP];
  ste_quant_t chan_mem [NUM_SP];
  logic [TS_W-1:0] start_mem [NUM_SP];

  // per set point state vectors
  logic [NUM_SP-1:0] loaded_r;
  logic [NUM_SP-1:0] seen_r;
  logic [NUM_SP-1:0] h1_r;
  logic [NUM_SP-1:0] h2_r;
  logic [NUM_SP-1:0] pend_r;
  logic [NUM_SP-1:0] trip_r;
  logic [NUM_SP-1:0] blank_r;
  logic [NUM_SP-1:0] blink_r;
  logic [NUM_SP-1:0] clr_r;
  logic [NUM_SP-1:0] clr_nxt;

  // scanner and time base
  logic [SP_IDX_W-1:0] scan_r;
  logic [TS_W-1:0] ms_now_r;
  logic tick_w;

  // output registers
  logic blank_out_r;
  logic blink_out_r;
  logic evt_valid_r;
  ste_evt_t evt_r;

  // current point under evaluation
  ste_cfg_t cfg_w;
  ste_quant_t smp_w;
  logic [NUM_SP-1:0] sel_w;
  logic active_w;
  logic hit1_w;
  logic hit2_w;
  logic cond_w;
  logic [TS_W-1:0] elapsed_w;
  logic [TS_W-1:0] delay_w;
  logic timed_w;
  logic hold_w;
  logic trip_nxt;
  logic rise_w;
  logic start_w;
  logic [DLY_W-1:0] dly_lim_w;
  logic scr_blank_w;
  logic scr_blink_w;
  logic scr_msg_w;
  ste_evt_t evt_nxt;

  // millisecond enable for the trip delay
  ste_tick #(
    .P_CYCLES(P_TICK_CYCLES)
  ) u_tick (
    .i_clk_sys(i_clk_sys),
    .i_rst_n(i_rst_n),
    .o_tick(tick_w)
  );

  // first threshold
  ste_cmp u_cmp1 (
    .i_quant(smp_w),
    .i_qsel(cfg_w.first_quantity_select),
    .i_op(cfg_w.op1),
    .i_value(cfg_w.value1),
    .i_ofs(cfg_w.ofs),
    .i_was_on(h1_r[scan_r]),
    .o_hit(hit1_w)
  );

  // second threshold shares the same offsets
  ste_cmp u_cmp2 (
    .i_quant(smp_w),
    .i_qsel(cfg_w.second_quantity_select),
    .i_op(cfg_w.op2),
    .i_value(cfg_w.value2),
    .i_ofs(cfg_w.ofs),
    .i_was_on(h2_r[scan_r]),
    .o_hit(hit2_w)
  );

  // lookup of the scanned point and its source channel
  assign cfg_w = cfg_mem[scan_r];
  assign smp_w = chan_mem[cfg_w.src];
  assign sel_w = NUM_SP'(1) << scan_r;

  // point runs only when loaded, enabled and globally allowed
  assign active_w = loaded_r[scan_r] & cfg_w.enable & i_global_setpoint_enable & seen_r[cfg_w.src];

  // joining of the two comparisons
  assign cond_w = (cfg_w.threshold_combine_mode == CMB_AND) ? (hit1_w & hit2_w) :
                  (cfg_w.threshold_combine_mode == CMB_OR) ? (hit1_w | hit2_w) : hit1_w;

  // delay measured against a free millisecond stamp; wrap is harmless below 65 s
  assign elapsed_w = ms_now_r - start_mem[scan_r];
  // settings above the ten-second ceiling are held at the ceiling
  assign dly_lim_w = (cfg_w.delay_ms > DLY_W'(MAX_DELAY_MS)) ? DLY_W'(MAX_DELAY_MS) : cfg_w.delay_ms;
  assign delay_w = TS_W'(dly_lim_w);
  assign timed_w = (pend_r[scan_r] && (elapsed_w >= delay_w)) || (delay_w == '0);
  // timing starts afresh on each new true condition
  assign start_w = active_w & cond_w & ~pend_r[scan_r];

  // latch hold unless a clear is pending for this point
  assign hold_w = cfg_w.latch & trip_r[scan_r] & ~clr_r[scan_r];

  // new trip state, condition held through the delay
  assign trip_nxt = active_w & ((cond_w & (trip_r[scan_r] | timed_w)) | hold_w);
  // only a false-to-true change raises the event
  assign rise_w = trip_nxt & ~trip_r[scan_r];

  // display effect asked for by the scanned point
  assign scr_blank_w = (cfg_w.screen == SCR_BLANK);
  assign scr_blink_w = (cfg_w.screen == SCR_BLINK);
  assign scr_msg_w = (cfg_w.screen == SCR_MSG);

  // fields of a new event; message routing is local to each point
  assign evt_nxt = '{idx: scan_r,
                     to_serial: cfg_w.msg_to_serial,
                     to_display: cfg_w.msg_to_display & scr_msg_w};

  // a fresh clear command wins over the scan retiring an older one
  assign clr_nxt = i_clr_latch ? {NUM_SP{1'b1}} : (clr_r & ~sel_w);

  // parameter writes keep the store intact across enable changes
  always_ff @(posedge i_clk_sys) begin
    if (i_cfg_wr) begin
      cfg_mem[i_cfg_idx] <= i_cfg;
    end
  end

  // channel samples replace the stored value for that channel
  always_ff @(posedge i_clk_sys) begin
    if (i_chan_valid) begin
      chan_mem[i_chan_idx] <= i_chan_sample;
    end
  end

  // delay start stamp per point
  always_ff @(posedge i_clk_sys) begin
    if (start_w) begin
      start_mem[scan_r] <= ms_now_r;
    end
  end

  // which points and channels hold valid contents
  always_ff @(posedge i_clk_sys) begin
    if (!i_rst_n) begin
      loaded_r <= SP_VEC_RST;
      seen_r <= SP_VEC_RST;
    end else begin
      if (i_cfg_wr) begin
        loaded_r[i_cfg_idx] <= 1'b1;
      end
      if (i_chan_valid) begin
        seen_r[i_chan_idx] <= 1'b1;
      end
    end
  end

  // round-robin scan, every point revisited each 32 cycles
  always_ff @(posedge i_clk_sys) begin
    if (!i_rst_n) begin
      scan_r <= '0;
      ms_now_r <= TS_RST;
    end else begin
      scan_r <= scan_r + SP_IDX_W'(1);
      if (tick_w) begin
        ms_now_r <= ms_now_r + TS_W'(1);
      end
    end
  end

  // pending clear-latch flags, one per point
  always_ff @(posedge i_clk_sys) begin
    if (!i_rst_n) begin
      clr_r <= SP_VEC_RST;
    end else begin
      clr_r <= clr_nxt;
    end
  end

  // per point comparison, delay and trip state
  always_ff @(posedge i_clk_sys) begin
    if (!i_rst_n) begin
      h1_r <= SP_VEC_RST;
      h2_r <= SP_VEC_RST;
      pend_r <= SP_VEC_RST;
      trip_r <= SP_VEC_RST;
    end else begin
      h1_r[scan_r] <= active_w & hit1_w;
      h2_r[scan_r] <= active_w & hit2_w;
      pend_r[scan_r] <= active_w & cond_w;
      trip_r[scan_r] <= trip_nxt;
    end
  end

  // display effects while tripped
  always_ff @(posedge i_clk_sys) begin
    if (!i_rst_n) begin
      blank_r <= SP_VEC_RST;
      blink_r <= SP_VEC_RST;
    end else begin
      blank_r[scan_r] <= trip_nxt & scr_blank_w;
      blink_r[scan_r] <= trip_nxt & scr_blink_w;
    end
  end

  // merged display outputs, one cycle behind the vectors
  always_ff @(posedge i_clk_sys) begin
    if (!i_rst_n) begin
      blank_out_r <= 1'b0;
      blink_out_r <= 1'b0;
    end else begin
      blank_out_r <= |blank_r;
      blink_out_r <= |blink_r;
    end
  end

  // event strobe, one cycle per new trip; one point per cycle so no collisions
  always_ff @(posedge i_clk_sys) begin
    if (!i_rst_n) begin
      evt_valid_r <= 1'b0;
    end else begin
      evt_valid_r <= rise_w;
    end
  end

  // event fields hold until the next trip so a slow reader still sees them
  always_ff @(posedge i_clk_sys) begin
    if (!i_rst_n) begin
      evt_r <= '0;
    end else if (rise_w) begin
      evt_r <= evt_nxt;
    end
  end

  // fixed mapping of low points to relays and LEDs, not reassignable
  assign o_relay = trip_r[NUM_RELAY-1:0];
  assign o_logic_out = trip_r[NUM_RELAY];
  assign o_led = trip_r[NUM_LED-1:0];
  assign o_trip = trip_r;
  assign o_blank = blank_out_r;
  assign o_blink = blink_out_r;
  assign o_evt_valid = evt_valid_r;
  assign o_evt = evt_r;

endmodule : ste_top

// ===== sim/ste_top_sva.sv
// checker for the set point evaluator outputs
`timescale 1ns/1ns
module ste_top_sva
  import ste_pkg::*;
#(
  parameter int P_TICK_CYCLES = ste_pkg::TICK_CYCLES
) (
  // clock and reset
  input wire logic i_clk_sys,
  input wire logic i_rst_n,
  // control level
  input wire logic i_global_setpoint_enable,
  // watched outputs
  input wire logic [ste_pkg::NUM_RELAY-1:0] o_relay,
  input wire logic o_logic_out,
  input wire logic [ste_pkg::NUM_LED-1:0] o_led,
  input wire logic [ste_pkg::NUM_SP-1:0] o_trip,
  input wire logic o_blank,
  input wire logic o_blink,
  input wire logic o_evt_valid,
  input ste_pkg::ste_evt_t o_evt
);
  default clocking @(posedge i_clk_sys); endclocking
  default disable iff (!i_rst_n);
  // trip history and length of the global-off stretch, saturating
  logic [NUM_SP-1:0] trip_d1_r;
  logic [5:0] off_cnt_r;
  always_ff @(posedge i_clk_sys) begin
    trip_d1_r <= o_trip;
    off_cnt_r <= (!i_rst_n || i_global_setpoint_enable) ? 6'h00 : off_cnt_r + 6'(off_cnt_r != 6'h3f);
  end
  property p_relay_map;
    {o_logic_out, o_relay} == o_trip[7:0];
  endproperty
  a_relay_map: assert property (p_relay_map) else $error("relay outputs differ from trip state");
  property p_led_map;
    o_led == o_trip[1:0];
  endproperty
  a_led_map: assert property (p_led_map) else $error("leds differ from trip state");
  property p_evt_new;
    o_evt_valid |-> o_trip[o_evt.idx] && !trip_d1_r[o_evt.idx];
  endproperty
  a_evt_new: assert property (p_evt_new) else $error("event without a fresh trip");
  property p_evt_hold;
    !o_evt_valid |-> $stable(o_evt);
  endproperty
  a_evt_hold: assert property (p_evt_hold) else $error("event fields moved without event");
  // the scanner sets at most one new point per cycle
  property p_one_new;
    $onehot0(o_trip & ~$past(o_trip));
  endproperty
  a_one_new: assert property (p_one_new) else $error("several points tripped in one cycle");
  property p_display;
    (o_blank || o_blink) |-> $past(o_trip) != '0;
  endproperty
  a_display: assert property (p_display) else $error("blank or blink without a tripped point");
  property p_global_clear;
    off_cnt_r >= 6'd40 |-> o_trip == '0 && !o_blank && !o_blink;
  endproperty
  a_global_clear: assert property (p_global_clear) else $error("outputs on while globally off");
  property p_global_quiet;
    !i_global_setpoint_enable [*3] |-> !o_evt_valid;
  endproperty
  a_global_quiet: assert property (p_global_quiet) else $error("event while globally off");
endmodule : ste_top_sva

bind ste_top ste_top_sva #(.P_TICK_CYCLES(P_TICK_CYCLES)) u_sva (
  .i_clk_sys(i_clk_sys), .i_rst_n(i_rst_n), .i_global_setpoint_enable(i_global_setpoint_enable),
  .o_relay(o_relay), .o_logic_out(o_logic_out), .o_led(o_led), .o_trip(o_trip),
  .o_blank(o_blank), .o_blink(o_blink), .o_evt_valid(o_evt_valid), .o_evt(o_evt));

// ===== sim/ste_chan_src.sv
// channel list source model feeding samples to the evaluator
`timescale 1ns/1ns
module ste_chan_src
  import ste_pkg::*;
(
  // clock and bench request
  input wire logic i_clk_sys,
  input wire logic i_req,
  input wire logic [ste_pkg::SP_IDX_W-1:0] i_idx,
  input ste_pkg::ste_quant_t i_val,
  // towards the evaluator
  output logic o_valid,
  output logic [ste_pkg::SP_IDX_W-1:0] o_idx,
  output ste_pkg::ste_quant_t o_sample
);
  initial begin
    o_valid = 1'b0;
    o_idx = '0;
    o_sample = '0;
  end
  // one-cycle strobe; idle data inverted so a stale value never passes for fresh
  always @(posedge i_clk_sys) begin
    o_valid <= i_req;
    o_idx <= i_req ? i_idx : ~o_idx;
    o_sample <= i_req ? i_val : ~o_sample;
  end
endmodule : ste_chan_src

// ===== sim/testbench.sv
// self-checking bench for the set point evaluator
`timescale 1ns/1ns
module testbench;
  import ste_pkg::*;
  logic clk = 1'b0, rst_n = 1'b0, cfg_wr = 1'b0, req = 1'b0, gen = 1'b1, clr = 1'b0;
  logic [4:0] cfg_idx = '0, sidx = '0, cidx;
  ste_cfg_t cfg = '0;
  ste_quant_t sval = '0, samp;
  logic valid, lout, evt_v, blank, blink;
  logic [6:0] relay;
  logic [1:0] led;
  logic [31:0] trip;
  ste_evt_t evt, last_evt = '0;
  int errors = 0, n_tests = 0, n_evt = 0;

  always #4 clk = ~clk;

  ste_chan_src u_src (.i_clk_sys(clk), .i_req(req), .i_idx(sidx), .i_val(sval),
    .o_valid(valid), .o_idx(cidx), .o_sample(samp));
  ste_top #(.P_TICK_CYCLES(4)) uut (.i_clk_sys(clk), .i_rst_n(rst_n), .i_cfg_wr(cfg_wr),
    .i_cfg_idx(cfg_idx), .i_cfg(cfg), .i_chan_valid(valid), .i_chan_idx(cidx), .i_chan_sample(samp),
    .i_global_setpoint_enable(gen), .i_clr_latch(clr), .o_relay(relay), .o_logic_out(lout),
    .o_led(led), .o_trip(trip), .o_blank(blank), .o_blink(blink), .o_evt_valid(evt_v), .o_evt(evt));

  // events of point two only
  always @(posedge clk) if (evt_v === 1'b1 && evt.idx === 5'd1) begin
    n_evt <= n_evt + 1;
    last_evt <= evt;
  end

  task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
    n_tests++;
    if (seen !== exp) begin
      errors++;
      $display("FAIL %s expected %h seen %h", nm, exp, seen);
    end
  endtask : chk

  task automatic close_out();
    if (errors == 0 && n_tests > 0) $display("No errors found");
    else $display("Errors were found");
    $finish;
  endtask : close_out

  // latency up to 33 cycles plus one for display outputs
  task automatic settle();
    repeat (40) @(posedge clk);
  endtask : settle

  task automatic wcfg(input int k, input ste_cfg_t c);
    cfg_wr <= 1'b1;
    cfg_idx <= 5'(k);
    cfg <= c;
    @(posedge clk);
    cfg_wr <= 1'b0;
    @(posedge clk);
  endtask : wcfg

  task automatic send(input logic [4:0] ch, input ste_quant_t q);
    req <= 1'b1;
    sidx <= ch;
    sval <= q;
    @(posedge clk);
    req <= 1'b0;
    @(posedge clk);
  endtask : send

  task automatic feed(input logic [4:0] ch, input int g);
    send(ch, '{gross: g, default: 32'sd0});
    settle();
  endtask : feed

  // expected comparison result including offsets and hysteresis
  function automatic logic hit(ste_op_t op, logic signed [31:0] v, logic signed [31:0] q, ste_ofs_t o, logic was);
    logic lt;
    logic signed [31:0] th;
    lt = op == OP_LT || op == OP_LE;
    th = lt ? v + 32'(o.preact) - 32'(o.postact) : v - 32'(o.preact) + 32'(o.postact);
    if (was) th = lt ? th + 32'(o.deadzone) : th - 32'(o.deadzone);
    case (op)
      OP_GT: return q > th;
      OP_GE: return q >= th;
      OP_LT: return q < th;
      OP_LE: return q <= th;
      default: return 1'b0;
    endcase
  endfunction : hit

  function automatic logic signed [31:0] qv(ste_quant_t q, ste_qsel_t sel);
    case (sel)
      Q_GROSS: return q.gross;
      Q_NET: return q.net;
      Q_TOTAL: return q.total;
      default: return q.weighment_count;
    endcase
  endfunction : qv

  // quantities scattered around either threshold
  function automatic ste_quant_t rq(ste_cfg_t c);
    ste_quant_t q;
    for (int i = 0; i < 4; i++) q[32*i +: 32] = ($urandom_range(1) ? c.value1 : c.value2) + $urandom_range(120) - 60;
    return q;
  endfunction : rq

  // hang guard
  initial begin
    repeat (90000) @(posedge clk);
    errors++;
    close_out();
  end

  initial begin
    ste_cfg_t c;
    ste_quant_t s;
    int k;
    logic w1, w2, h1, h2, e;
    void'($urandom(32'h05ff));
    repeat (3) @(posedge clk);
    rst_n <= 1'b1;
    @(posedge clk);
    // points one to eight trip, all blinking
    c = '0;
    c.enable = 1'b1;
    c.op1 = OP_GT;
    c.screen = SCR_BLINK;
    for (int i = 0; i < 8; i++) begin
      c.src = 5'(i);
      send(c.src, '{default: 32'sd5});
      wcfg(i, c);
    end
    settle();
    chk("relays", {lout, relay}, 32'hff);
    chk("leds", led, 32'h3);
    chk("blink", blink, 32'h1);
    for (int i = 0; i < 8; i++) wcfg(i, '0);
    settle();
    chk("relays off", {lout, relay}, 32'h0);
    chk("blink off", blink, 32'h0);
    // latching point two on channel two, blanking
    c = '0;
    c.enable = 1'b1;
    c.latch = 1'b1;
    c.op1 = OP_GT;
    c.value1 = 100;
    c.src = 5'd2;
    c.screen = SCR_BLANK;
    c.msg_to_serial = 1'b1;
    feed(2, 0);
    wcfg(1, c);
    settle();
    feed(2, 200);
    chk("events", n_evt, 32'd2);
    chk("event", last_evt, {5'd1, 2'b10});
    chk("blank", blank, 32'h1);
    feed(2, 300);
    chk("events", n_evt, 32'd2);
    feed(2, 0);
    chk("latched", trip[1], 32'h1);
    clr <= 1'b1;
    @(posedge clk);
    clr <= 1'b0;
    settle();
    chk("cleared", trip[1], 32'h0);
    chk("blank off", blank, 32'h0);
    feed(2, 200);
    chk("events", n_evt, 32'd3);
    gen <= 1'b0;
    settle();
    chk("global off", trip[1], 32'h0);
    gen <= 1'b1;
    settle();
    chk("global on", n_evt, 32'd4);
    c.enable = 1'b0;
    wcfg(1, c);
    settle();
    chk("disabled", trip[1], 32'h0);
    c.enable = 1'b1;
    c.screen = SCR_MSG;
    c.msg_to_display = 1'b1;
    wcfg(1, c);
    settle();
    chk("event", last_evt, {5'd1, 2'b11});
    // trip delay of five ticks on point four
    c = '0;
    c.enable = 1'b1;
    c.op1 = OP_GT;
    c.value1 = 100;
    c.src = 5'd4;
    c.delay_ms = 14'd5;
    feed(4, 0);
    wcfg(3, c);
    settle();
    send(4, '{gross: 200, default: 32'sd0});
    // one scan period after the sample: evaluated once, delay still running
    repeat (33) @(posedge clk);
    chk("early", trip[3], 32'h0);
    repeat (67) @(posedge clk);
    chk("delayed", trip[3], 32'h1);
    // true for one scan, false for one, then true again: delay must start over
    feed(4, 0);
    send(4, '{gross: 200, default: 32'sd0});
    repeat (30) @(posedge clk);
    send(4, '{default: 32'sd0});
    repeat (30) @(posedge clk);
    send(4, '{gross: 200, default: 32'sd0});
    repeat (33) @(posedge clk);
    chk("aborted", trip[3], 32'h0);
    repeat (32) @(posedge clk);
    chk("restarted", trip[3], 32'h1);
    // random set points against the comparison model
    for (int n = 0; n < 30; n++) begin
      k = $urandom_range(31);
      c = '0;
      c.enable = 1'b1;
      c.threshold_combine_mode = ste_cmb_t'($urandom_range(2));
      c.op1 = ste_op_t'($urandom_range(4));
      c.op2 = ste_op_t'($urandom_range(4));
      c.first_quantity_select = ste_qsel_t'($urandom_range(3));
      c.second_quantity_select = ste_qsel_t'($urandom_range(3));
      c.src = 5'($urandom_range(31));
      c.value1 = $urandom_range(2000) - 1000;
      c.value2 = $urandom_range(2000) - 1000;
      c.ofs = {24'($urandom_range(30)), 24'($urandom_range(30)), 24'($urandom_range(30))};
      wcfg(k, '0);
      settle();
      w1 = 1'b0;
      w2 = 1'b0;
      for (int m = 0; m < 8; m++) begin
        s = rq(c);
        send(c.src, s);
        if (m == 0) wcfg(k, c);
        settle();
        h1 = hit(c.op1, c.value1, qv(s, c.first_quantity_select), c.ofs, w1);
        h2 = hit(c.op2, c.value2, qv(s, c.second_quantity_select), c.ofs, w2);
        w1 = h1;
        w2 = h2;
        e = c.threshold_combine_mode == CMB_AND ? h1 && h2 : c.threshold_combine_mode == CMB_OR ? h1 || h2 : h1;
        chk("trip", trip[k], e);
      end
      send(c.src + 5'd1, rq(c));
      settle();
      chk("other source", trip[k], e);
    end
    close_out();
  end
endmodule : testbench
